// ==== rtl/rsb_pkg.sv ====
/*
  Package for the reset source and break flag register bank.
  Assumes a 32-bit AXI4-Lite register bus, each register one aligned word.
*/
package rsb_pkg;
  // ==========================================================
  // Register byte addresses
  localparam logic [3:0] RSB_BREAK_WAIT_STATUS_ADDR = 4'h0;
  localparam logic [3:0] RSB_RESET_CAUSE_STATUS_ADDR = 4'h4;
  localparam logic [3:0] RSB_BREAK_FLAG_CONTROL_ADDR = 4'h8;
  localparam logic [3:0] RSB_IRQ_STATUS_ADDR = 4'hc;
  // ==========================================================
  // Field positions
  localparam int RSB_BWS_EXIT_BIT = 1;
  localparam int RSB_RC_POWER_ON_BIT = 7;
  localparam int RSB_RC_PIN_BIT = 6;
  localparam int RSB_RC_WATCHDOG_BIT = 5;
  localparam int RSB_RC_BAD_OPCODE_BIT = 4;
  localparam int RSB_RC_BAD_FETCH_BIT = 3;
  localparam int RSB_RC_UNDERVOLTAGE_BIT = 1;
  localparam int RSB_BFC_CLEAR_ENABLE_BIT = 7;
  // Interrupt status layout: bit 0 break wait exit, bit 1 new reset cause
  localparam int RSB_IRQ_BREAK_EXIT_BIT = 0;
  localparam int RSB_IRQ_RESET_CAUSE_BIT = 1;
  localparam int RSB_IRQ_W = 2;
  // ==========================================================
  // Reset values
  localparam logic [7:0] RSB_RC_POWER_ON_VALUE = 8'h80;
  localparam logic [7:0] RSB_BFC_RESET = 8'h00;
  // ==========================================================
  // AXI responses
  localparam logic [1:0] RSB_RESP_OKAY = 2'h0;
  localparam logic [1:0] RSB_RESP_SLVERR = 2'h2;
endpackage

// ==== rtl/rsb_sync3.sv ====
/*
  Three-flop synchroniser for one asynchronous level.
  Assumes the input may change at any time; the output is the agreed level.
*/
`timescale 1ns/1ps
`default_nettype none
module rsb_sync3 (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Level in and out
  input wire logic d,
  output logic q
);
  logic s1_r, s2_r, s3_r, q_r;
  logic q_nxt;

  always_comb begin
    // Change counts once stages two and three agree
    q_nxt = (s2_r == s3_r) ? s3_r : q_r;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      q_r <= 1'b0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r <= q_nxt;
    end
  end

  assign q = q_r;
endmodule
`default_nettype wire

// ==== rtl/rsb_reset_source_break_flags.sv ====
/*
  Reset source flags, break wait exit flag and break clear enable,
  with an AXI4-Lite slave and one level interrupt.
  Assumes reset cause levels arrive from other domains (synchronised here)
  and that cause inputs still stand when the system reset releases.
*/
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module rsb_reset_source_break_flags
  import rsb_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Reset causes, levels from other domains
  input wire logic power_on_reset,
  input wire logic reset_pin_active,
  input wire logic watchdog_reset,
  input wire logic bad_opcode_reset,
  input wire logic bad_fetch_reset,
  input wire logic opcode_fetch,
  input wire logic undervoltage_reset,
  // Wait and break, same clock
  input wire logic wait_mode,
  input wire logic cpu_interrupt,
  input wire logic break_interrupt,
  input wire logic break_state,
  // Outputs
  output logic wait_exit_request,
  output logic status_clear_allowed,
  output logic irq
);
  // ==========================================================
  // Synchronised cause levels
  logic por_s, pin_s, wd_s, op_s, fa_s, fetch_s, uv_s;

  // Synchronisers restart with the bank, so no unknown level leaks past reset
  rsb_sync3 u_sync_por (.aclk(aclk), .aresetn(aresetn), .d(power_on_reset), .q(por_s));
  rsb_sync3 u_sync_pin (.aclk(aclk), .aresetn(aresetn), .d(reset_pin_active), .q(pin_s));
  rsb_sync3 u_sync_wd (.aclk(aclk), .aresetn(aresetn), .d(watchdog_reset), .q(wd_s));
  rsb_sync3 u_sync_op (.aclk(aclk), .aresetn(aresetn), .d(bad_opcode_reset), .q(op_s));
  rsb_sync3 u_sync_fa (.aclk(aclk), .aresetn(aresetn), .d(bad_fetch_reset), .q(fa_s));
  rsb_sync3 u_sync_fe (.aclk(aclk), .aresetn(aresetn), .d(opcode_fetch), .q(fetch_s));
  rsb_sync3 u_sync_uv (.aclk(aclk), .aresetn(aresetn), .d(undervoltage_reset), .q(uv_s));

  // ==========================================================
  // State
  logic [7:0] cause_r, cause_nxt;
  logic exit_flag_r, exit_flag_nxt;
  logic [7:0] bfc_r, bfc_nxt;
  logic [RSB_IRQ_W-1:0] irq_stat_r, irq_stat_nxt;
  logic [RSB_IRQ_W-1:0] irq_en_r, irq_en_nxt;
  logic wait_exit_r, wait_exit_nxt;
  logic clr_ok_r, clr_ok_nxt;
  logic irq_r, irq_nxt;
  logic awready_r, awready_nxt, wready_r, wready_nxt, bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic [3:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic have_aw_r, have_aw_nxt, have_w_r, have_w_nxt;
  logic arready_r, arready_nxt, rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic cause_rd_pending_r, cause_rd_pending_nxt;
  logic held_r, held_nxt;

  // Any active cause (system still held in reset)
  logic any_cause;
  logic wr_fire, rd_take;
  logic [7:0] new_cause;

  function automatic logic [31:0] rsb_read_word(input logic [3:0] a, input logic [7:0] c,
      input logic e, input logic [7:0] b, input logic [RSB_IRQ_W-1:0] s);
    logic [31:0] w;
    w = 32'h0;
    case (a)
      RSB_BREAK_WAIT_STATUS_ADDR: w[RSB_BWS_EXIT_BIT] = e;
      RSB_RESET_CAUSE_STATUS_ADDR: w[7:0] = c;
      RSB_BREAK_FLAG_CONTROL_ADDR: w[7:0] = b;
      RSB_IRQ_STATUS_ADDR: w[RSB_IRQ_W-1:0] = s;
      default: w = 32'h0;
    endcase
    return w;
  endfunction

  function automatic logic rsb_mapped(input logic [3:0] a);
    return (a == RSB_BREAK_WAIT_STATUS_ADDR) || (a == RSB_RESET_CAUSE_STATUS_ADDR) ||
           (a == RSB_BREAK_FLAG_CONTROL_ADDR) || (a == RSB_IRQ_STATUS_ADDR);
  endfunction

  // ==========================================================
  // Next-state logic
  always_comb begin
    any_cause = por_s | pin_s | wd_s | op_s | (fa_s & fetch_s) | uv_s;
    new_cause = 8'h00;
    new_cause[RSB_RC_PIN_BIT] = pin_s;
    new_cause[RSB_RC_WATCHDOG_BIT] = wd_s;
    new_cause[RSB_RC_BAD_OPCODE_BIT] = op_s;
    new_cause[RSB_RC_BAD_FETCH_BIT] = fa_s & fetch_s;
    new_cause[RSB_RC_UNDERVOLTAGE_BIT] = uv_s;

    // Write channel capture, either order
    awready_nxt = awready_r;
    wready_nxt = wready_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    have_aw_nxt = have_aw_r;
    have_w_nxt = have_w_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    if (s_axi_awvalid && awready_r) begin
      have_aw_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
      awready_nxt = 1'b0;
    end
    if (s_axi_wvalid && wready_r) begin
      have_w_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
      wready_nxt = 1'b0;
    end
    wr_fire = have_aw_r && have_w_r && !bvalid_r;
    if (wr_fire) begin
      bvalid_nxt = 1'b1;
      bresp_nxt = rsb_mapped(awaddr_r) ? RSB_RESP_OKAY : RSB_RESP_SLVERR;
      have_aw_nxt = 1'b0;
      have_w_nxt = 1'b0;
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
      awready_nxt = 1'b1;
      wready_nxt = 1'b1;
    end
  end

  // Read channel
  always_comb begin
    // Read channel; data snapshot before any clear
    arready_nxt = arready_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    cause_rd_pending_nxt = cause_rd_pending_r;
    rd_take = s_axi_arvalid && arready_r;
    if (rd_take) begin
      arready_nxt = 1'b0;
      rvalid_nxt = 1'b1;
      rdata_nxt = rsb_read_word(s_axi_araddr, cause_r, exit_flag_r, bfc_r, irq_stat_r);
      rresp_nxt = rsb_mapped(s_axi_araddr) ? RSB_RESP_OKAY : RSB_RESP_SLVERR;
      cause_rd_pending_nxt = (s_axi_araddr == RSB_RESET_CAUSE_STATUS_ADDR);
    end
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
      arready_nxt = 1'b1;
      cause_rd_pending_nxt = 1'b0;
    end
  end

  // Flags, break enable and wait exit
  always_comb begin
    // Reset cause flags
    cause_nxt = cause_r;
    held_nxt = any_cause;
    if (rvalid_r && s_axi_rready && cause_rd_pending_r) begin
      cause_nxt = 8'h00; // Clear only once the read completes
    end
    if (por_s) begin
      cause_nxt = RSB_RC_POWER_ON_VALUE;
    end else if (any_cause) begin
      cause_nxt = new_cause; // Latest reset overwrites older causes
    end

    // Break wait exit flag; set wins over software clear
    exit_flag_nxt = exit_flag_r;
    if (wr_fire && awaddr_r == RSB_BREAK_WAIT_STATUS_ADDR && wstrb_r[0] &&
        !wdata_r[RSB_BWS_EXIT_BIT]) begin
      exit_flag_nxt = 1'b0;
    end
    if (wait_mode && break_interrupt) begin
      exit_flag_nxt = 1'b1;
    end
    if (any_cause) begin
      exit_flag_nxt = 1'b0;
    end

    // Break clear enable
    bfc_nxt = bfc_r;
    if (wr_fire && awaddr_r == RSB_BREAK_FLAG_CONTROL_ADDR && wstrb_r[0]) begin
      bfc_nxt = 8'h00;
      bfc_nxt[RSB_BFC_CLEAR_ENABLE_BIT] = wdata_r[RSB_BFC_CLEAR_ENABLE_BIT];
    end
    if (any_cause) begin
      bfc_nxt = RSB_BFC_RESET;
    end
    clr_ok_nxt = !break_state || bfc_nxt[RSB_BFC_CLEAR_ENABLE_BIT];

    // Wait exit request
    wait_exit_nxt = wait_mode && (pin_s || cpu_interrupt || break_interrupt);
  end

  // Interrupt status
  always_comb begin
    // Interrupt status: enable and clear share layout, set wins
    irq_en_nxt = irq_en_r;
    irq_stat_nxt = irq_stat_r;
    if (wr_fire && awaddr_r == RSB_IRQ_STATUS_ADDR && wstrb_r[0]) begin
      irq_stat_nxt = irq_stat_r & ~wdata_r[RSB_IRQ_W-1:0];
    end
    if (wr_fire && awaddr_r == RSB_IRQ_STATUS_ADDR && wstrb_r[1]) begin
      irq_en_nxt = wdata_r[8 +: RSB_IRQ_W];
    end
    if (wait_mode && break_interrupt) begin
      irq_stat_nxt[RSB_IRQ_BREAK_EXIT_BIT] = 1'b1;
    end
    if (held_r && !any_cause) begin
      irq_stat_nxt[RSB_IRQ_RESET_CAUSE_BIT] = 1'b1;
    end
    irq_nxt = |(irq_stat_nxt & irq_en_nxt);
  end

  // ==========================================================
  // Registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cause_r <= RSB_RC_POWER_ON_VALUE;
      exit_flag_r <= 1'b0;
      bfc_r <= RSB_BFC_RESET;
      wait_exit_r <= 1'b0;
      clr_ok_r <= 1'b1;
      held_r <= 1'b0;
    end else begin
      cause_r <= cause_nxt;
      exit_flag_r <= exit_flag_nxt;
      bfc_r <= bfc_nxt;
      wait_exit_r <= wait_exit_nxt;
      clr_ok_r <= clr_ok_nxt;
      held_r <= held_nxt;
    end
  end

  // Interrupt registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_r <= '0;
      irq_en_r <= '0;
      irq_r <= 1'b0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      irq_en_r <= irq_en_nxt;
      irq_r <= irq_nxt;
    end
  end

  // Write channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= RSB_RESP_OKAY;
      awaddr_r <= 4'h0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      have_aw_r <= 1'b0;
      have_w_r <= 1'b0;
    end else begin
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      have_aw_r <= have_aw_nxt;
      have_w_r <= have_w_nxt;
    end
  end

  // Read channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= RSB_RESP_OKAY;
      cause_rd_pending_r <= 1'b0;
    end else begin
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      cause_rd_pending_r <= cause_rd_pending_nxt;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign wait_exit_request = wait_exit_r;
  assign status_clear_allowed = clr_ok_r;
  assign irq = irq_r;
endmodule
`default_nettype wire

// ==== tb/rsb_far_model.sv ====
/*
  Far side model: reset sources, CPU wait and break lines.
  Assumes the bench drives fire and the selects just after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module rsb_far_model (
  // Clock
  input wire logic aclk,
  // Commands from the bench
  input wire logic fire,
  input wire logic [6:0] cause_sel,
  input wire logic [3:0] cpu_sel,
  // Lines toward the block
  output logic [6:0] cause_lines,
  output logic [3:0] cpu_lines
);
  logic [2:0] cnt_r = 3'h0;
  logic [6:0] cause_r = 7'h00;
  logic [3:0] cpu_r = 4'h0;
  // A reset source holds its request several cycles, never a one-cycle glitch
  always @(posedge aclk) begin
    cnt_r <= fire ? 3'h5 : ((cnt_r != 3'h0) ? cnt_r - 3'h1 : 3'h0);
    cause_r <= (fire || cnt_r > 3'h1) ? cause_sel : 7'h00;
    cpu_r <= cpu_sel;
  end
  assign cause_lines = cause_r;
  assign cpu_lines = cpu_r;
endmodule
`default_nettype wire

// ==== tb/rsb_asserts.sv ====
/*
  Concurrent checks on the reset source and break flag bank.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module rsb_checker
  import rsb_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  // Wait and break
  input wire logic wait_mode,
  input wire logic cpu_interrupt,
  input wire logic break_interrupt,
  input wire logic break_state,
  input wire logic wait_exit_request,
  input wire logic status_clear_allowed
);
  // ==========================================================
  // Which register the read under way targets
  logic rd_rc_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_rc_r <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rd_rc_r <= (s_axi_araddr == RSB_RESET_CAUSE_STATUS_ADDR);
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // Properties
  a_exit_on_event:
    assert property (wait_mode && (cpu_interrupt || break_interrupt) |=> wait_exit_request)
    else $error("wait exit not requested");
  a_exit_when_idle:
    assert property (!wait_mode |=> !wait_exit_request)
    else $error("wait exit requested outside wait");
  a_clear_out_break:
    assert property (!break_state |=> status_clear_allowed)
    else $error("clearing blocked outside break");
  a_six_flags:
    assert property (s_axi_rvalid && rd_rc_r |-> s_axi_rdata[2] == 1'b0 && s_axi_rdata[0] == 1'b0)
    else $error("unused reset cause bit set");
  a_upper_zero:
    assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  a_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  a_read_refused:
    assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken during answer");
  a_write_answer:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid)
    else $error("write answer late");
endmodule
bind rsb_reset_source_break_flags rsb_checker rsb_checker_inst (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .wait_mode, .cpu_interrupt, .break_interrupt, .break_state, .wait_exit_request,
  .status_clear_allowed
);
`default_nettype wire

// ==== tb/rsb_reset_source_break_flags_bench.sv ====
/*
  Self-checking bench for the reset source and break flag bank.
  Assumes the far side model and a bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module rsb_reset_source_break_flags_bench
  import rsb_pkg::*;
;
  logic aclk, aresetn, fire, irq, wait_exit_request, status_clear_allowed;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb, cpu_sel, cpu_lines;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [6:0] cause_sel, cause_lines;
  int err_count, n_compared;
  // Cause vector: por, pin, watchdog, opcode, fetch, opcode fetch, undervoltage
  logic [6:0] ctab [7] = '{7'h20, 7'h10, 7'h08, 7'h06, 7'h01, 7'h04, 7'h40};
  logic [7:0] etab [7] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h02, 8'h00, 8'h80};
  localparam logic [3:0] A_BWS = RSB_BREAK_WAIT_STATUS_ADDR;
  localparam logic [3:0] A_RC = RSB_RESET_CAUSE_STATUS_ADDR;
  localparam logic [3:0] A_BFC = RSB_BREAK_FLAG_CONTROL_ADDR;
  localparam logic [3:0] A_IRQ = RSB_IRQ_STATUS_ADDR;
  localparam logic [1:0] R_OK = RSB_RESP_OKAY;
  rsb_reset_source_break_flags rsb_reset_source_break_flags_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .power_on_reset(cause_lines[6]), .reset_pin_active(cause_lines[5]),
    .watchdog_reset(cause_lines[4]), .bad_opcode_reset(cause_lines[3]),
    .bad_fetch_reset(cause_lines[2]), .opcode_fetch(cause_lines[1]),
    .undervoltage_reset(cause_lines[0]), .wait_mode(cpu_lines[3]), .cpu_interrupt(cpu_lines[2]),
    .break_interrupt(cpu_lines[1]), .break_state(cpu_lines[0]), .wait_exit_request,
    .status_clear_allowed, .irq
  );
  rsb_far_model rsb_far_model_inst (.aclk, .fire, .cause_sel, .cpu_sel, .cause_lines, .cpu_lines);
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // ==========================================================
  // Tasks
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task give_verdict;
    if (err_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Handshake flags are sampled at the falling edge, where registered outputs are settled
  task wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    logic fa, fw, fb;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    fb = 1'b0;
    for (int n = 0; n < 40 && !fb; n++) begin
      @(negedge aclk);
      fa = s_axi_awready;
      fw = s_axi_wready;
      fb = s_axi_bvalid;
      if (fb) chk("bresp", {30'h0, RSB_RESP_OKAY}, {30'h0, s_axi_bresp});
      @(posedge aclk);
      if (fa) s_axi_awvalid <= 1'b0;
      if (fw) s_axi_wvalid <= 1'b0;
      if (fb) s_axi_bready <= 1'b0;
    end
    if (!fb) begin
      err_count++;
      give_verdict();
    end
  endtask
  task rdc(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
    logic fa, fr;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    fr = 1'b0;
    for (int n = 0; n < 40 && !fr; n++) begin
      @(negedge aclk);
      fa = s_axi_arready;
      fr = s_axi_rvalid;
      if (fr) chk("rdata", e, s_axi_rdata);
      if (fr) chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
      @(posedge aclk);
      if (fa) s_axi_arvalid <= 1'b0;
      if (fr) s_axi_rready <= 1'b0;
    end
    if (!fr) begin
      err_count++;
      give_verdict();
    end
  endtask
  // Long settle covers the three-flop synchronisers on the cause lines
  task cause_ev(input logic [6:0] v);
    @(posedge aclk);
    cause_sel <= v;
    fire <= 1'b1;
    @(posedge aclk);
    fire <= 1'b0;
    repeat (14) @(posedge aclk);
  endtask
  task cpu_ev(input logic [3:0] v);
    @(posedge aclk);
    cpu_sel <= v;
    @(posedge aclk);
    cpu_sel <= 4'h0;
    repeat (3) @(posedge aclk);
  endtask
  task do_reset;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    {fire, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, cpu_sel, cause_sel} = 23'h0;
    s_axi_wdata = 32'h0;
    err_count = 0;
    n_compared = 0;
    do_reset();
    rdc(A_RC, 32'h80, RSB_RESP_OKAY);
    rdc(A_RC, 32'h0, RSB_RESP_OKAY);
    for (int i = 0; i < 7; i++) begin
      cause_ev(ctab[i]);
      rdc(A_RC, {24'h0, etab[i]}, R_OK);
      rdc(A_RC, 32'h0, RSB_RESP_OKAY);
    end
    // Reset pin during wait asks for wait exit
    cpu_sel <= 4'h8;
    @(posedge aclk);
    cause_sel <= 7'h20;
    fire <= 1'b1;
    @(posedge aclk);
    fire <= 1'b0;
    repeat (7) @(negedge aclk);
    chk("wait_exit", 32'h1, {31'h0, wait_exit_request});
    repeat (8) @(posedge aclk);
    cpu_sel <= 4'h0;
    rdc(A_RC, 32'h40, RSB_RESP_OKAY);
    rdc(A_IRQ, 32'h2, RSB_RESP_OKAY);
    wr(A_IRQ, 32'h3, 4'h1);
    wr(A_IRQ, 32'h100, 4'h3);
    cpu_ev(4'hc);
    rdc(A_BWS, 32'h0, RSB_RESP_OKAY);
    @(negedge aclk);
    chk("irq", 32'h0, {31'h0, irq});
    cpu_ev(4'ha);
    rdc(A_BWS, 32'h2, RSB_RESP_OKAY);
    rdc(A_IRQ, 32'h1, RSB_RESP_OKAY);
    @(negedge aclk);
    chk("irq", 32'h1, {31'h0, irq});
    wr(A_BWS, 32'h0, 4'h1);
    rdc(A_BWS, 32'h0, RSB_RESP_OKAY);
    wr(A_IRQ, 32'h1, 4'h1);
    @(negedge aclk);
    chk("irq", 32'h0, {31'h0, irq});
    wr(A_BFC, 32'h80, 4'h1);
    rdc(A_BFC, 32'h80, RSB_RESP_OKAY);
    cpu_sel <= 4'h1;
    repeat (3) @(negedge aclk);
    chk("clear_allowed", 32'h1, {31'h0, status_clear_allowed});
    wr(A_BFC, 32'h0, 4'h1);
    repeat (2) @(negedge aclk);
    chk("clear_allowed", 32'h0, {31'h0, status_clear_allowed});
    rdc(4'h2, 32'h0, RSB_RESP_SLVERR);
    cpu_ev(4'ha);
    do_reset();
    rdc(A_BWS, 32'h0, RSB_RESP_OKAY);
    rdc(A_RC, 32'h80, RSB_RESP_OKAY);
    give_verdict();
  end
endmodule
`default_nettype wire
